// File: core/lbrw_pkg.sv
/*
  Shared constants, types and command codes for the low-power DDR host
  controller that drives a four-bank memory through its command and data pins.
  Assumes a 20 MHz reference clock; the memory clock is that clock divided
  by two, so one reference cycle is one half period of the memory clock.
*/
// Behaviour
// - Open a row with ACTIVE before access.
// - Wait activate-to-column delay before read or write.
// - Precharge first; space same-bank ACTIVEs by row cycle.
// - Space ACTIVEs to different banks by bank delay.
// - Follow-on READ issued after wanted pair count.
// - Burst stop issued after wanted pair count.
// - Burst stop only for lengths four and eight.
// - Finish or stop read before issuing WRITE.
// - Precharge after read; then wait precharge period.
// - Hold write strobe low for preamble, postamble.
// - First write strobe rise near one clock.
// - Follow-on WRITE issued after wanted pair count.
// - Wait write-to-read delay before a following READ.
// - Mask write data cut short by READ.
// - Wait write recovery before precharge, then precharge.
// - Row cycle 55 ns; column, precharge 15 ns.
// - Write-to-read delay at least two clocks.
package lbrw_pkg;

  // Clock rates: the memory clock is the reference divided by two.
  localparam int CLK_PERIOD_NS = 50;
  localparam int MEM_PERIOD_NS = 2 * CLK_PERIOD_NS;

  // Least times in nanoseconds, write-to-read in memory cycles, as the memory requires them.
  localparam int ROW_CYCLE_NS = 55;
  localparam int ACT_TO_COL_NS = 15;
  localparam int PRECHARGE_NS = 15;
  localparam int MIN_ACTIVE_NS = 42;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int BANK_TO_BANK_NS = 15;
  localparam int WRITE_TO_READ_CYC = 2;

  // Least times round up to whole memory cycles, never below one.
  function automatic int mem_cycles(input int ns);
    int c;
    c = (ns + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : mem_cycles

  // Age counters saturate at their top value.
  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] TMR_MAX = 4'hf;
  localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;
  localparam logic [TMR_W-1:0] ROW_CYCLE_CNT =
    TMR_W'(mem_cycles(ROW_CYCLE_NS));
  localparam logic [TMR_W-1:0] ACT_TO_COL_CNT =
    TMR_W'(mem_cycles(ACT_TO_COL_NS));
  localparam logic [TMR_W-1:0] PRECHARGE_CNT =
    TMR_W'(mem_cycles(PRECHARGE_NS));
  localparam logic [TMR_W-1:0] MIN_ACTIVE_CNT =
    TMR_W'(mem_cycles(MIN_ACTIVE_NS));
  localparam logic [TMR_W-1:0] WRITE_RECOVERY_CNT =
    TMR_W'(mem_cycles(WRITE_RECOVERY_NS));
  localparam logic [TMR_W-1:0] BANK_TO_BANK_CNT =
    TMR_W'(mem_cycles(BANK_TO_BANK_NS));
  localparam logic [TMR_W-1:0] WRITE_TO_READ_CNT = TMR_W'(WRITE_TO_READ_CYC);

  // Array and bus widths.
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 32;
  localparam int DM_W = 4;
  localparam int CNT_W = 6;

  // Address bit ten selects auto precharge on column commands.
  localparam logic [ADDR_W-1:0] AP_MASK = 13'h0400;

  // Command codes, bits are chip select, row, column and write strobes.
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;

  // One user access request.
  typedef struct packed {
    logic write;
    logic auto_pre;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } lbrw_req_t;

  // Command pins as one group.
  typedef struct packed {
    logic [3:0] code;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } lbrw_cmd_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    S_IDLE, S_OPEN, S_COL, S_BURST, S_AUTOPRE
  } lbrw_state_t;

endpackage : lbrw_pkg

// File: core/lbrw_bank.sv
/*
  Per-bank tracker: open row and ages of the last activate, precharge and
  write end, counted in memory cycles, giving the go signals for each command.
  Assumes tick is a one-cycle pulse once per memory clock period.
*/
`timescale 1ns/1ps
module lbrw_bank (
  // Clock, reset and memory-cycle enable
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  // Events on this bank
  input wire logic act,
  input wire logic pre,
  input wire logic wr_end,
  input wire logic [lbrw_pkg::ROW_W-1:0] row_in,
  // Bank state and go signals
  output logic is_open,
  output logic [lbrw_pkg::ROW_W-1:0] open_row,
  output logic col_ok,
  output logic act_ok,
  output logic pre_ok
);
  import lbrw_pkg::*;

  logic open_q;
  logic [ROW_W-1:0] row_q;
  logic [TMR_W-1:0] act_age_q;
  logic [TMR_W-1:0] pre_age_q;
  logic [TMR_W-1:0] wr_age_q;
  wire logic [TMR_W-1:0] act_inc;
  wire logic [TMR_W-1:0] pre_inc;
  wire logic [TMR_W-1:0] wr_inc;

  // Saturating increments, so an idle bank never wraps back to "young".
  assign act_inc = (act_age_q == TMR_MAX) ? TMR_MAX : act_age_q + TMR_ONE;
  assign pre_inc = (pre_age_q == TMR_MAX) ? TMR_MAX : pre_age_q + TMR_ONE;
  assign wr_inc = (wr_age_q == TMR_MAX) ? TMR_MAX : wr_age_q + TMR_ONE;

  always_ff @(posedge clk) begin
    if (rst) begin
      open_q <= 1'b0;
      row_q <= '0;
    end else if (act) begin
      open_q <= 1'b1;
      row_q <= row_in;
    end else if (pre) begin
      open_q <= 1'b0;
    end
  end

  // Ages start at the top after reset so the first command is not held.
  always_ff @(posedge clk) begin
    if (rst) begin
      act_age_q <= TMR_MAX;
      pre_age_q <= TMR_MAX;
      wr_age_q <= TMR_MAX;
    end else begin
      act_age_q <= act ? '0 : (tick ? act_inc : act_age_q);
      pre_age_q <= pre ? '0 : (tick ? pre_inc : pre_age_q);
      wr_age_q <= wr_end ? '0 : (tick ? wr_inc : wr_age_q);
    end
  end

  assign is_open = open_q;
  assign open_row = row_q;
  assign col_ok = open_q && (act_age_q >= ACT_TO_COL_CNT);
  assign act_ok = !open_q && (act_age_q >= ROW_CYCLE_CNT)
                  && (pre_age_q >= PRECHARGE_CNT);
  assign pre_ok = open_q && (act_age_q >= MIN_ACTIVE_CNT)
                  && (wr_age_q >= WRITE_RECOVERY_CNT);

endmodule : lbrw_bank

// File: core/lbrw_ctrl.sv
/*
  Host-side sequencer for a four-bank low-power DDR memory: opens rows,
  issues reads and writes with optional auto precharge, and burst stop on reads only,
  drives write data with its strobe and captures read data by latency.
  Assumes the memory pins are synchronous to REF_CLK and that the board
  resolves the two-way data and strobe pins from the enables.
*/
`timescale 1ns/1ps
module lbrw_ctrl #(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT = 3
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // User requests
  input wire logic REQ_VALID,
  input wire lbrw_pkg::lbrw_req_t REQ,
  output logic REQ_READY,
  input wire logic STOP_REQ,
  // Write data stream
  input wire logic [lbrw_pkg::DQ_W-1:0] WR_DATA,
  input wire logic [lbrw_pkg::DM_W-1:0] WR_MASK,
  output logic WD_TAKE,
  // Read data stream
  output logic [lbrw_pkg::DQ_W-1:0] RD_DATA,
  output logic RD_VALID,
  // Memory clock and commands
  output logic CK,
  output logic CK_N,
  output logic CKE,
  output lbrw_pkg::lbrw_cmd_t MEM_CMD,
  // Memory data, strobe and mask
  input wire logic [lbrw_pkg::DQ_W-1:0] DQ_IN,
  output logic [lbrw_pkg::DQ_W-1:0] DQ_OUT,
  output logic DQ_OE,
  input wire logic [lbrw_pkg::DM_W-1:0] DQS_IN,
  output logic [lbrw_pkg::DM_W-1:0] DQS_OUT,
  output logic DQS_OE,
  output logic [lbrw_pkg::DM_W-1:0] DM
);
  import lbrw_pkg::*;

  // Burst timing in reference cycles counted from the column command.
  localparam logic [CNT_W-1:0] BL_CNT = CNT_W'(BURST_LEN);
  localparam logic [CNT_W-1:0] RD_FIRST = CNT_W'(2 + 2 * CAS_LAT);
  localparam logic [CNT_W-1:0] WR_END = CNT_W'(BURST_LEN + 5);
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic BST_ALLOWED = (BURST_LEN == 4) || (BURST_LEN == 8);

  lbrw_state_t state_q, state_d;
  lbrw_req_t req_q;
  lbrw_cmd_t cmd_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] rd_len_q;
  logic [TMR_W-1:0] rrd_age_q;
  logic [TMR_W-1:0] wtr_age_q;
  logic ck_q, ck_n_q, cke_q, ready_q;
  logic wd_take_q, rd_valid_q, dq_oe_q, dqs_oe_q;
  logic [DQ_W-1:0] dq_q, rd_data_q;
  logic [DM_W-1:0] dqs_q, dm_q;

  wire logic tick_w;
  wire logic accept_w;
  wire logic [NUM_BANKS-1:0] bank_open_w, col_ok_w, act_ok_w, pre_ok_w;
  wire logic [ROW_W-1:0] bank_row_w [NUM_BANKS];
  wire logic sel_open_w, hit_w, rrd_ok_w, wtr_ok_w;
  wire logic issue_act_w, issue_pre_w, issue_col_w, issue_rd_w, issue_wr_w;
  wire logic issue_bst_w, ap_mark_w, burst_end_w, wr_end_w, cap_w;
  wire logic in_wr_w;
  wire logic [CNT_W-1:0] end_cnt_w;
  wire logic [ADDR_W-1:0] col_addr_w;
  wire lbrw_cmd_t cmd_w;

  // Memory clock divider; commands launch as CK falls so they are
  // stable half a period before the rising edge that samples them.
  assign tick_w = ck_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ck_q <= 1'b0;
      ck_n_q <= 1'b1;
      cke_q <= 1'b0;
    end else begin
      ck_q <= ~ck_q;
      ck_n_q <= ck_q;
      cke_q <= 1'b1;
    end
  end

  // One tracker per bank.
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    wire logic sel_b;
    assign sel_b = (req_q.bank == BANK_W'(b));
    lbrw_bank u_bank (
      .clk(REF_CLK),
      .rst(RESET),
      .tick(tick_w),
      .act(issue_act_w && sel_b),
      .pre((issue_pre_w || ap_mark_w) && sel_b),
      .wr_end(wr_end_w && sel_b),
      .row_in(req_q.row),
      .is_open(bank_open_w[b]),
      .open_row(bank_row_w[b]),
      .col_ok(col_ok_w[b]),
      .act_ok(act_ok_w[b]),
      .pre_ok(pre_ok_w[b])
    );
  end

  // Selected-bank status and the global spacing checks.
  assign sel_open_w = bank_open_w[req_q.bank];
  assign hit_w = sel_open_w && (bank_row_w[req_q.bank] == req_q.row);
  assign rrd_ok_w = rrd_age_q >= BANK_TO_BANK_CNT;
  assign wtr_ok_w = wtr_age_q >= WRITE_TO_READ_CNT;
  assign accept_w = (state_q == S_IDLE) && ready_q && REQ_VALID;

  assign issue_pre_w = (state_q == S_OPEN) && tick_w && sel_open_w
                       && !hit_w && pre_ok_w[req_q.bank];
  assign issue_act_w = (state_q == S_OPEN) && tick_w && !sel_open_w
                       && act_ok_w[req_q.bank] && rrd_ok_w;
  // next column only after the burst, full or stopped, has ended.
  assign issue_col_w = (state_q == S_COL) && tick_w && col_ok_w[req_q.bank]
                       && (req_q.write || wtr_ok_w);
  assign issue_rd_w = issue_col_w && !req_q.write;
  assign issue_wr_w = issue_col_w && req_q.write;
  // stop after the pairs already read.
  assign issue_bst_w = (state_q == S_BURST) && !req_q.write && STOP_REQ
                       && tick_w && BST_ALLOWED && (cnt_q >= 6'h02)
                       && (cnt_q < rd_len_q);
  assign ap_mark_w = (state_q == S_AUTOPRE) && tick_w && pre_ok_w[req_q.bank];
  assign end_cnt_w = req_q.write ? WR_END : RD_FIRST + rd_len_q;
  assign burst_end_w = (state_q == S_BURST) && (cnt_q == end_cnt_w);
  assign wr_end_w = burst_end_w && req_q.write;

  assign col_addr_w = ADDR_W'(req_q.col) | (req_q.auto_pre ? AP_MASK : '0);
  assign cmd_w.code = issue_act_w ? CMD_ACT :
                      issue_pre_w ? CMD_PRE :
                      issue_rd_w ? CMD_RD :
                      issue_wr_w ? CMD_WR :
                      issue_bst_w ? CMD_BST : CMD_NOP;
  assign cmd_w.ba = req_q.bank;
  assign cmd_w.addr = issue_act_w ? req_q.row :
                      issue_col_w ? col_addr_w : '0;

  // Sequencer: one access at a time, rows kept open after use unless auto precharge is asked.
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (accept_w) begin
          state_d = S_OPEN;
        end
      end
      S_OPEN: begin
        if (hit_w || issue_act_w) begin
          state_d = S_COL;
        end
      end
      S_COL: begin
        if (issue_col_w) begin
          state_d = S_BURST;
        end
      end
      S_BURST: begin
        if (burst_end_w) begin
          state_d = req_q.auto_pre ? S_AUTOPRE : S_IDLE;
        end
      end
      S_AUTOPRE: begin
        if (ap_mark_w) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Burst cycle counter, 1 in the cycle the column command is on the pins.
  assign cnt_d = issue_col_w ? CNT_ONE :
                 (state_q == S_BURST && !burst_end_w) ? cnt_q + CNT_ONE : '0;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_q <= S_IDLE;
      ready_q <= 1'b0;
      cnt_q <= '0;
      cmd_q <= '{code: CMD_NOP, ba: '0, addr: '0};
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == S_IDLE);
      cnt_q <= cnt_d;
      cmd_q <= cmd_w;
    end
  end

  // Request capture and read length; a burst stop shortens the read.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      req_q <= '0;
      rd_len_q <= '0;
    end else begin
      if (accept_w) begin
        req_q <= REQ;
      end
      if (issue_rd_w) begin
        rd_len_q <= BL_CNT;
      end else if (issue_bst_w) begin
        rd_len_q <= cnt_q;
      end
    end
  end

  // Global ages: any activate, and the end of the last write burst.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rrd_age_q <= TMR_MAX;
      wtr_age_q <= TMR_MAX;
    end else begin
      if (issue_act_w) begin
        rrd_age_q <= '0;
      end else if (tick_w && rrd_age_q != TMR_MAX) begin
        rrd_age_q <= rrd_age_q + TMR_ONE;
      end
      if (wr_end_w) begin
        wtr_age_q <= '0;
      end else if (tick_w && wtr_age_q != TMR_MAX) begin
        wtr_age_q <= wtr_age_q + TMR_ONE;
      end
    end
  end

  // Write data path. The column command reaches the memory at count 2,
  // the first strobe rise comes at count 4, exactly one memory clock later,
  // which sits in the middle of the allowed window.
  assign in_wr_w = (cnt_d != '0) && req_q.write;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wd_take_q <= 1'b0;
      dq_oe_q <= 1'b0;
      dqs_oe_q <= 1'b0;
      dqs_q <= '0;
      dq_q <= '0;
      dm_q <= '0;
    end else begin
      wd_take_q <= in_wr_w && (cnt_d >= 6'h02) && (cnt_d <= BL_CNT + 6'h01);
      dq_oe_q <= in_wr_w && (cnt_d >= 6'h03) && (cnt_d <= BL_CNT + 6'h03);
      // strobe low before and after data.
      dqs_oe_q <= in_wr_w && (cnt_d >= 6'h03) && (cnt_d <= BL_CNT + 6'h04);
      // first rise one clock after WRITE.
      dqs_q <= {DM_W{in_wr_w && (cnt_d >= 6'h04)
                     && (cnt_d <= BL_CNT + 6'h03) && !cnt_d[0]}};
      if (wd_take_q) begin
        dq_q <= WR_DATA;
        dm_q <= WR_MASK;
      end
    end
  end

  assign cap_w = (state_q == S_BURST) && !req_q.write
                 && (cnt_q >= RD_FIRST) && (cnt_q < RD_FIRST + rd_len_q);
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= cap_w;
      if (cap_w) begin
        rd_data_q <= DQ_IN;
      end
    end
  end

  assign REQ_READY = ready_q;
  assign WD_TAKE = wd_take_q;
  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign CK = ck_q;
  assign CK_N = ck_n_q;
  assign CKE = cke_q;
  assign MEM_CMD = cmd_q;
  assign DQ_OUT = dq_q;
  assign DQ_OE = dq_oe_q;
  assign DQS_OUT = dqs_q;
  assign DQS_OE = dqs_oe_q;
  assign DM = dm_q;

  // Checks on the commands and strobes this controller drives.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_col_row_open: assert property (
    issue_col_w |-> hit_w)
    else $error("column command to a bank without the addressed row open");
  a_col_after_act: assert property (
    issue_act_w |=> !issue_col_w [*2])
    else $error("column command too soon after activate");
  a_act_same_bank: assert property (
    issue_act_w |-> !sel_open_w ##1 sel_open_w)
    else $error("activate to a bank with a row still open");
  a_act_spacing: assert property (
    issue_act_w |=> !issue_act_w [*2])
    else $error("activates closer than the bank-to-bank delay");
  a_bst_burst_len: assert property (
    issue_bst_w |-> BST_ALLOWED && !req_q.write ##1 hit_w)
    else $error("burst stop outside a read or with a bad length");
  a_wr_preamble: assert property (
    $rose(dqs_oe_q) |-> dqs_q == '0 ##1 dqs_q != '0)
    else $error("write strobe preamble is not one low half cycle");
  a_wr_postamble: assert property (
    $fell(dqs_oe_q) |-> $past(dqs_q) == '0)
    else $error("write strobe postamble is not low");
  a_wr_first_rise: assert property (
    issue_wr_w |=> (dqs_q == '0) [*3] ##1 (dqs_q != '0))
    else $error("first write strobe rise not one clock after WRITE");
  a_wtr_wait: assert property (
    wr_end_w |=> !issue_rd_w [*4])
    else $error("read issued inside the write-to-read delay");
  a_bus_turn: assert property (
    dq_oe_q |-> !cap_w)
    else $error("driving data while a read burst is being captured");

  c_write_done: cover property (wr_end_w);
  c_read_done: cover property (burst_end_w && !req_q.write && DQS_IN != '0);
  c_burst_stop: cover property (issue_bst_w ##[1:20] burst_end_w);
  c_auto_pre: cover property (ap_mark_w);

endmodule : lbrw_ctrl

// File: verification/lbrw_mem_model.sv
/*
  Behavioural model of the four-bank memory behind the host controller.
  Assumes commands are sampled on every REF_CLK rising edge and that
  one memory clock equals two reference cycles.
*/
`timescale 1ns/1ps
module lbrw_mem_model #(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command pins and write side from the host
  input wire lbrw_pkg::lbrw_cmd_t cmd,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe,
  input wire logic [3:0] dqs_out,
  input wire logic dqs_oe,
  input wire logic [3:0] dm,
  // Read side back to the host and count of host faults
  output logic [31:0] dq_in,
  output logic [3:0] dqs_in,
  output logic [7:0] viol
);
  import lbrw_pkg::*;
  logic [31:0] mem [logic [23:0]];
  logic open_q [4];
  logic [12:0] row_q [4];
  int age [4];
  int rt, rlim, wt, wn, ap_cnt, v, i, ro, wo;
  logic [1:0] b, ap_bank;
  logic [23:0] rkey, wkey;
  logic dqs_q;
  logic [31:0] dq_q, cur;
  logic [3:0] dm_q;

  // One process holds bank state, read launch and write capture.
  always @(posedge clk) begin
    if (rst) begin
      rt = 0; wt = 0; wn = BURST_LEN; ap_cnt = 0; dqs_q = 0;
      foreach (open_q[k]) open_q[k] = 0;
      viol <= 8'h00; dq_in <= 32'h0; dqs_in <= 4'h0;
    end else begin
      v = 0; ro = rt; wo = wt; b = cmd.ba;
      foreach (age[k]) age[k]++;
      i = ro - 2 * CAS_LAT;
      if (ro == 2 * CAS_LAT - 1) begin
        dqs_in <= 4'h0;
        dq_in <= ~dq_in;
      end else if (ro != 0 && i >= 0 && i < rlim) begin
        dq_in <= mem.exists(rkey + i) ? mem[rkey + i] : ~dq_in;
        dqs_in <= {4{~i[0]}};
      end else begin
        dq_in <= ~dq_in;
        dqs_in <= ~dqs_in;
      end
      if (rt != 0) rt = (rt > 2 * CAS_LAT + BURST_LEN + 2) ? 0 : rt + 1;
      if (wt != 0) wt++;
      // Capture on strobe edges, then ignore the rest.
      if (wo != 0 && wn < BURST_LEN && dqs_oe && (dqs_out[0] != dqs_q)
          && (wn > 0 || dqs_out[0])) begin
        // First rise one memory clock after the command.
        if (wn == 0 && wo != 3) v++;
        // Data must be driven while the strobe captures it.
        if (!dq_oe) v++;
        cur = mem.exists(wkey + wn) ? mem[wkey + wn] : 32'h0;
        for (int j = 0; j < 4; j++) if (!dm_q[j]) cur[8*j+:8] = dq_q[8*j+:8];
        mem[wkey + wn] = cur;
        wn++;
      end
      // Auto precharge closes the row BURST_LEN reference cycles after the command.
      if (ap_cnt != 0) begin
        ap_cnt--;
        if (ap_cnt == 0) open_q[ap_bank] = 0;
      end
      case (cmd.code)
        CMD_ACT: begin
          // Row must be closed and a row cycle gone by.
          if (open_q[b] || age[b] < 2) v++;
          open_q[b] = 1; row_q[b] = cmd.addr; age[b] = 0;
        end
        CMD_PRE: open_q[b] = 0;
        // Access to an open, settled row.
        CMD_RD, CMD_WR: begin
          if (!open_q[b] || age[b] < 2) v++;
          if (cmd.addr[10]) begin
            ap_cnt = BURST_LEN; ap_bank = b;
          end
          if (cmd.code == CMD_RD) begin
            rkey = {b, row_q[b], cmd.addr[8:0]}; rt = 1; rlim = BURST_LEN;
          end else begin
            wkey = {b, row_q[b], cmd.addr[8:0]}; wt = 1; wn = 0;
          end
        end
        // Burst stop keeps the pairs already asked for.
        CMD_BST: if (rt != 0) rlim = rt - 1;
        default: ;
      endcase
      dqs_q = dqs_oe & dqs_out[0]; dq_q = dq_out; dm_q = dm;
      viol <= viol + v[7:0];
    end
  end
endmodule : lbrw_mem_model

// File: verification/lbrw_ctrl_bench.sv
/*
  Self-checking bench for the host controller against the memory model.
  Assumes inputs change on the falling edge and a 50 ns reference clock.
*/
`timescale 1ns/1ps
module lbrw_ctrl_bench;
  import lbrw_pkg::*;
  logic REF_CLK, RESET, REQ_VALID, REQ_READY, STOP_REQ, WD_TAKE, RD_VALID;
  logic CK, CK_N, CKE, DQ_OE, DQS_OE;
  lbrw_req_t REQ;
  lbrw_cmd_t MEM_CMD;
  logic [31:0] WR_DATA, RD_DATA, DQ_IN, DQ_OUT;
  logic [3:0] WR_MASK, DQS_IN, DQS_OUT, DM;
  logic [7:0] viol;
  int mismatches, check_count, wk, n_act, n_pre, n_bst;
  logic [31:0] wdat [4];
  logic [3:0] wmsk [4];
  logic [31:0] rdq [$];
  logic [31:0] ref_mem [logic [23:0]];

  lbrw_ctrl #(.BURST_LEN(4), .CAS_LAT(3)) dut (.REF_CLK(REF_CLK),
    .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
    .STOP_REQ(STOP_REQ), .WR_DATA(WR_DATA), .WR_MASK(WR_MASK),
    .WD_TAKE(WD_TAKE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .CK(CK),
    .CK_N(CK_N), .CKE(CKE), .MEM_CMD(MEM_CMD), .DQ_IN(DQ_IN),
    .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQS_IN(DQS_IN), .DQS_OUT(DQS_OUT),
    .DQS_OE(DQS_OE), .DM(DM));
  lbrw_mem_model #(.BURST_LEN(4), .CAS_LAT(3)) mem (.clk(REF_CLK),
    .rst(RESET), .cmd(MEM_CMD), .dq_out(DQ_OUT), .dq_oe(DQ_OE),
    .dqs_out(DQS_OUT), .dqs_oe(DQS_OE), .dm(DM), .dq_in(DQ_IN),
    .dqs_in(DQS_IN), .viol(viol));

  // Clock, and a watchdog far beyond the few hundred cycles needed.
  initial begin
    REF_CLK = 0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  initial begin
    repeat (5000) @(posedge REF_CLK);
    mismatches++;
    conclude();
  end

  // Count commands and gather read elements as they are delivered.
  always @(posedge REF_CLK) begin
    if (MEM_CMD.code === CMD_ACT) n_act++;
    if (MEM_CMD.code === CMD_PRE) n_pre++;
    if (MEM_CMD.code === CMD_BST) n_bst++;
    if (RD_VALID === 1'b1) rdq.push_back(RD_DATA);
  end

  // Hand out one write element per cycle of the take signal.
  always @(negedge REF_CLK) begin
    if (WD_TAKE === 1'b1) begin
      WR_DATA <= wdat[wk & 3];
      WR_MASK <= wmsk[wk & 3];
      wk <= wk + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // One full access; the reference copy keeps masked bytes as the memory does.
  task automatic access(input logic w, input logic ap, input logic [1:0] b,
                        input logic [12:0] r, input logic [8:0] c,
                        input logic stp);
    int k;
    logic [23:0] key;
    rdq.delete();
    wk = 0;
    k = 0;
    @(negedge REF_CLK);
    while (REQ_READY !== 1'b1 && k < 200) begin
      @(negedge REF_CLK);
      k++;
    end
    REQ_VALID = 1;
    REQ = '{w, ap, b, r, c};
    STOP_REQ = stp;
    @(negedge REF_CLK);
    REQ_VALID = 0;
    repeat (3) @(negedge REF_CLK);
    k = 0;
    while (REQ_READY !== 1'b1 && k < 200) begin
      @(negedge REF_CLK);
      k++;
    end
    STOP_REQ = 0;
    check("access done", 0, (k >= 200));
    if (w) for (int i = 0; i < 4; i++) begin
      key = {b, r, c + 9'(i)};
      if (!ref_mem.exists(key)) ref_mem[key] = 32'h0;
      for (int j = 0; j < 4; j++)
        if (!wmsk[i][j]) ref_mem[key][8*j+:8] = wdat[i][8*j+:8];
    end
  endtask : access

  task automatic rd_chk(input logic [1:0] b, input logic [12:0] r,
                        input logic [8:0] c, input int n);
    check("read count", n, rdq.size());
    for (int i = 0; i < n && i < rdq.size(); i++)
      check("read data", ref_mem[{b, r, c + 9'(i)}], rdq[i]);
  endtask : rd_chk

  task automatic t_reset();
    RESET = 1;
    repeat (8) @(negedge REF_CLK);
    check("ck_n in reset", 1, CK_N);
    check("ck in reset", 0, CK);
    check("req_ready in reset", 0, REQ_READY);
    check("cmd in reset", CMD_NOP, MEM_CMD.code);
    RESET = 0;
    @(negedge REF_CLK);
    check("cke after reset", 1, CKE);
    check("req_ready after reset", 1, REQ_READY);
  endtask : t_reset

  // Full write, masked rewrite on the open row, read back of the merge.
  task automatic t_write_read();
    int a;
    a = n_act;
    wdat = '{32'h11223344, 32'h55667788, 32'h99aabbcc, 32'hddeeff01};
    wmsk = '{4'h0, 4'h0, 4'h0, 4'h0};
    access(1, 0, 2'h1, 13'h0005, 9'h008, 0);
    check("act before write", a + 1, n_act);
    wdat = '{32'ha0a1a2a3, 32'hb0b1b2b3, 32'hc0c1c2c3, 32'hd0d1d2d3};
    wmsk = '{4'h0, 4'h5, 4'h0, 4'hf};
    access(1, 0, 2'h1, 13'h0005, 9'h008, 0);
    check("act on open row", a + 1, n_act);
    access(0, 0, 2'h1, 13'h0005, 9'h008, 0);
    rd_chk(2'h1, 13'h0005, 9'h008, 4);
  endtask : t_write_read

  // Auto precharge closes the row, so the next access opens it again.
  task automatic t_autopre();
    int a, p;
    a = n_act;
    p = n_pre;
    access(0, 1, 2'h1, 13'h0005, 9'h008, 0);
    rd_chk(2'h1, 13'h0005, 9'h008, 4);
    access(0, 0, 2'h1, 13'h0005, 9'h008, 0);
    check("act after auto pre", a + 1, n_act);
    check("no explicit pre", p, n_pre);
  endtask : t_autopre

  // Row miss in one bank, then a second bank opened beside it.
  task automatic t_row_miss();
    int a, p;
    a = n_act;
    p = n_pre;
    wdat = '{32'h01020304, 32'h05060708, 32'h090a0b0c, 32'h0d0e0f10};
    wmsk = '{4'h0, 4'h0, 4'h0, 4'h0};
    access(1, 0, 2'h1, 13'h0009, 9'h000, 0);
    check("pre on row miss", p + 1, n_pre);
    check("act on row miss", a + 1, n_act);
    access(1, 0, 2'h2, 13'h0009, 9'h000, 0);
    check("other bank pre", p + 1, n_pre);
  endtask : t_row_miss

  // Burst stop on a read, ignored on a write, then a read after the write.
  task automatic t_stop();
    int s;
    s = n_bst;
    access(0, 0, 2'h1, 13'h0009, 9'h000, 1);
    check("burst stop issued", s + 1, n_bst);
    rd_chk(2'h1, 13'h0009, 9'h000, 2);
    access(1, 0, 2'h1, 13'h0009, 9'h004, 1);
    check("no stop on write", s + 1, n_bst);
    access(0, 0, 2'h1, 13'h0009, 9'h004, 0);
    rd_chk(2'h1, 13'h0009, 9'h004, 4);
  endtask : t_stop

  // Main sequence with every input given a value at time zero.
  initial begin
    RESET = 1; REQ_VALID = 0; REQ = '0; STOP_REQ = 0;
    WR_DATA = 32'h0; WR_MASK = 4'h0; wk = 0;
    t_reset();
    t_write_read();
    t_autopre();
    t_row_miss();
    t_stop();
    check("host faults seen by memory", 0, viol);
    conclude();
  end
endmodule : lbrw_ctrl_bench
